// >>> rtl/power_state_pkg.sv
/*
 * Shared constants for the power state pin control block: register
 * addresses, field positions, reset values and the state encoding.
 * Assumes an 8-bit register address and 8-bit register data.
 */
package power_state_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_GPO_CTRL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
  localparam logic [7:0] ADDR_STATE = 8'h30;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h31;
  localparam logic [7:0] ADDR_RAIL_EN_LDO = 8'hA0;
  localparam logic [7:0] ADDR_RAIL_EN_SW = 8'hA1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int RAIL_LDO_B_BIT = 0;
  localparam int RAIL_LDO_C_BIT = 1;
  localparam int RAIL_SW_A_BIT = 0;
  localparam int GPO_BIT = 0;

  // Interrupt status and mask bits
  localparam int IRQ_STATE_BIT = 0;
  localparam int IRQ_HOT_BIT = 1;
  localparam int IRQ_TRIP_BIT = 2;
  localparam int IRQ_COLD_OFF_BIT = 3;
  localparam int IRQ_WIDTH = 4;

  // Pin status bits
  localparam int PIN_COLD_BOOT_BIT = 0;
  localparam int PIN_STANDBY_BIT = 1;
  localparam int PIN_SUSPEND_BIT = 2;
  localparam int PIN_HIBERNATE_BIT = 3;
  localparam int PIN_RAIL_EN_BIT = 4;
  localparam int PIN_TRIP_BIT = 5;
  localparam int PIN_HOT_BIT = 6;
  localparam int PIN_MODE_BIT = 7;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_GPO_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_RAIL_EN_LDO = 8'h00;
  localparam logic [7:0] RST_RAIL_EN_SW = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // ************************************************************
  // Power states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_MECH_OFF,
    ST_SOFT_OFF,
    ST_SUSPEND,
    ST_RUN,
    ST_STANDBY
  } power_state_t;

endpackage

// >>> rtl/pin_sync_edge.sv
/*
 * Two-stage synchroniser with edge detection for a group of pins.
 * Assumes the pins may change at any time relative to i_clk_sys.
 */
`timescale 1ns/1ps
module pin_sync_edge #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_LEVEL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] last;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_last;

  // ************************************************************
  // Synchroniser; first stage feeds only the second
  // ************************************************************
  always_comb begin
    next_meta = i_pin;
    next_stable = meta;
    next_last = stable;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= RST_LEVEL;
      stable <= RST_LEVEL;
      last <= RST_LEVEL;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  assign o_level = stable;
  assign o_rise = stable & ~last;
  assign o_fall = ~stable & last;

endmodule

// >>> rtl/power_state_pin_control.sv
/*
 * Pin-level power state control: sleep-state pins, rail enable gating,
 * open-drain status outputs and a small register file.
 * Assumes one 250 MHz clock, register master on the same clock, and
 * pins that may be asynchronous to it.
 */
// The address map and the address-and-strobe port were decided locally.
// Functional notes
// - Cold-boot rising edge moves mechanical off into soft off.
// - Cold-boot low turns every controlled regulator off.
// - Combined mode: enable pin drives both small LDOs and load switch.
// - Switch-only mode: enable pin drives only the load switch.
// - Enable pin high turns its resources on, low leaves them to the register bits.
// - With enable pin low, register enable bits control the rails.
// - Open-drain interrupt pin reflects pending interrupt register bits that are not masked.
// - Always-on power-good pin holds a valid level with supply present.
// - Global power-good pin holds a valid level with supply present.
// - General output pin follows a software-written register bit.
// - Thermal warning asserts while any die sensor reports hot.
// - Standby pin fall enters connected standby, rise leaves it.
// - Suspend pin fall enters S3, rise leaves S3 into S0.
// - Hibernate pin fall enters S4, rise leaves S4 into S3.
`timescale 1ns/1ps
module power_state_pin_control
  import power_state_pkg::*;
#(
  parameter int N_SENSORS = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cold_boot_in,
  input wire logic i_combined_rail_enable_in,
  input wire logic i_otp_combined_mode,
  input wire logic i_standby_sleep_in_n,
  input wire logic i_suspend_sleep_in_n,
  input wire logic i_hibernate_sleep_in_n,
  input wire logic i_thermal_trip_in_n,
  input wire logic [N_SENSORS-1:0] i_hot_threshold,
  input wire logic i_system_supply_ok,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [7:0] o_reg_rdata,
  output logic o_small_ldo_rail_b_en,
  output logic o_small_ldo_rail_c_en,
  output logic o_first_load_switch_en,
  output logic o_soft_off_rails_en,
  output logic o_suspend_rails_en,
  output logic o_run_rails_en,
  output logic o_interrupt_out_n,
  output logic o_interrupt_out_n_oe,
  output logic o_always_on_power_good_out,
  output logic o_always_on_power_good_out_oe,
  output logic o_global_power_good_out,
  output logic o_global_power_good_out_oe,
  output logic o_general_output_pin,
  output logic o_general_output_pin_oe,
  output logic o_thermal_warning_out,
  output logic o_thermal_warning_out_oe
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int NPIN = 6;
  localparam logic [NPIN-1:0] PIN_RST = 6'h3E;
  localparam int P_COLD = 0;
  localparam int P_STBY = 1;
  localparam int P_SUSP = 2;
  localparam int P_HIBR = 3;
  localparam int P_TRIP = 4;
  localparam int P_RAIL = 5;

  logic [NPIN-1:0] pin_lvl, pin_rise, pin_fall;
  logic [N_SENSORS-1:0] hot_lvl;

  pin_sync_edge #(
    .WIDTH(NPIN),
    .RST_LEVEL(PIN_RST & 6'h1E)
  ) u_pins (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin({i_combined_rail_enable_in, i_thermal_trip_in_n,
            i_hibernate_sleep_in_n, i_suspend_sleep_in_n,
            i_standby_sleep_in_n, i_cold_boot_in}),
    .o_level(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  pin_sync_edge #(
    .WIDTH(N_SENSORS),
    .RST_LEVEL('0)
  ) u_hot (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_hot_threshold),
    .o_level(hot_lvl),
    .o_rise(),
    .o_fall()
  );

  // ************************************************************
  // Power state machine
  // ************************************************************
  power_state_t state, next_state;
  logic trip_event;

  // Trip requested by the host as an active-low pulse or level
  assign trip_event = pin_fall[P_TRIP];

  always_comb begin
    next_state = state;
    if (!pin_lvl[P_COLD]) begin
      next_state = ST_MECH_OFF;
    end else if (trip_event) begin
      next_state = ST_MECH_OFF;
    end else begin
      case (state)
        ST_MECH_OFF: begin
          if (pin_rise[P_COLD]) begin
            next_state = ST_SOFT_OFF;
          end
        end
        ST_SOFT_OFF: begin
          if (pin_rise[P_HIBR]) begin
            next_state = ST_SUSPEND;
          end
        end
        ST_SUSPEND: begin
          if (pin_fall[P_HIBR]) begin
            next_state = ST_SOFT_OFF;
          end else if (pin_rise[P_SUSP]) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (pin_fall[P_HIBR]) begin
            next_state = ST_SOFT_OFF;
          end else if (pin_fall[P_SUSP]) begin
            next_state = ST_SUSPEND;
          end else if (pin_fall[P_STBY]) begin
            next_state = ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (pin_fall[P_HIBR]) begin
            next_state = ST_SOFT_OFF;
          end else if (pin_fall[P_SUSP]) begin
            next_state = ST_SUSPEND;
          end else if (pin_rise[P_STBY]) begin
            next_state = ST_RUN;
          end
        end
        default: begin
          next_state = ST_MECH_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_MECH_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] gpo_ctrl, rail_en_ldo, rail_en_sw;
  logic [7:0] next_gpo_ctrl, next_rail_en_ldo, next_rail_en_sw, next_rdata;
  logic [IRQ_WIDTH-1:0] irq_status, irq_mask, irq_set;
  logic [IRQ_WIDTH-1:0] next_irq_status, next_irq_mask;
  logic mode_combined, mode_taken, hot_any, hot_last;
  logic next_mode_combined, next_mode_taken;

  function automatic logic wr_hit(input logic [7:0] a);
    return i_reg_write && (i_reg_addr == a);
  endfunction

  assign hot_any = |hot_lvl;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_STATE_BIT] = (next_state != state);
    irq_set[IRQ_HOT_BIT] = hot_any && !hot_last;
    irq_set[IRQ_TRIP_BIT] = trip_event;
    irq_set[IRQ_COLD_OFF_BIT] = pin_fall[P_COLD];
  end

  always_comb begin
    next_gpo_ctrl = gpo_ctrl;
    next_rail_en_ldo = rail_en_ldo;
    next_rail_en_sw = rail_en_sw;
    next_irq_mask = irq_mask;
    // Strap is caught once, on the first edge after reset release
    next_mode_taken = 1'b1;
    next_mode_combined = mode_taken ? mode_combined : i_otp_combined_mode;
    if (wr_hit(ADDR_GPO_CTRL)) begin
      next_gpo_ctrl = i_reg_wdata;
    end
    if (wr_hit(ADDR_RAIL_EN_LDO)) begin
      next_rail_en_ldo = i_reg_wdata;
    end
    if (wr_hit(ADDR_RAIL_EN_SW)) begin
      next_rail_en_sw = i_reg_wdata;
    end
    if (wr_hit(ADDR_IRQ_MASK)) begin
      next_irq_mask = i_reg_wdata[IRQ_WIDTH-1:0];
    end
    // Write one to clear; a new event in the same cycle wins
    next_irq_status = irq_status;
    if (wr_hit(ADDR_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~i_reg_wdata[IRQ_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | irq_set;
    next_rdata = READ_NONE;
    if (i_reg_read) begin
      case (i_reg_addr)
        ADDR_GPO_CTRL: next_rdata = gpo_ctrl;
        ADDR_RAIL_EN_LDO: next_rdata = rail_en_ldo;
        ADDR_RAIL_EN_SW: next_rdata = rail_en_sw;
        ADDR_IRQ_STATUS: next_rdata = {4'h0, irq_status};
        ADDR_IRQ_MASK: next_rdata = {4'h0, irq_mask};
        ADDR_STATE: next_rdata = {5'h00, state};
        ADDR_PIN_STATUS: begin
          next_rdata = {mode_combined, hot_any, pin_lvl[P_TRIP],
                        pin_lvl[P_RAIL], pin_lvl[P_HIBR],
                        pin_lvl[P_SUSP], pin_lvl[P_STBY],
                        pin_lvl[P_COLD]};
        end
        default: next_rdata = READ_NONE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpo_ctrl <= RST_GPO_CTRL;
      rail_en_ldo <= RST_RAIL_EN_LDO;
      rail_en_sw <= RST_RAIL_EN_SW;
      irq_status <= '0;
      irq_mask <= RST_IRQ_MASK[IRQ_WIDTH-1:0];
      mode_combined <= 1'b0;
      mode_taken <= 1'b0;
      hot_last <= 1'b0;
      o_reg_rdata <= READ_NONE;
    end else begin
      gpo_ctrl <= next_gpo_ctrl;
      rail_en_ldo <= next_rail_en_ldo;
      rail_en_sw <= next_rail_en_sw;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      mode_combined <= next_mode_combined;
      mode_taken <= next_mode_taken;
      hot_last <= hot_any;
      o_reg_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Rail enables and open-drain pins
  // ************************************************************
  logic powered, pin_ldo, pin_sw;
  logic next_ldo_b, next_ldo_c, next_sw_a, next_soft, next_susp, next_run;
  logic next_irq_pull, next_aon_pull, next_glb_pull, next_gpo_pull;
  logic next_hot_pull;

  always_comb begin
    powered = pin_lvl[P_COLD] && (state != ST_MECH_OFF);
    // Pin owns the LDOs only in combined mode, the switch in both
    pin_ldo = mode_combined && pin_lvl[P_RAIL];
    pin_sw = pin_lvl[P_RAIL];
    // Register bits apply when the pin is low or does not own the rail
    next_ldo_b = powered && (pin_ldo || rail_en_ldo[RAIL_LDO_B_BIT]);
    next_ldo_c = powered && (pin_ldo || rail_en_ldo[RAIL_LDO_C_BIT]);
    next_sw_a = powered && (pin_sw || rail_en_sw[RAIL_SW_A_BIT]);
    next_soft = powered;
    next_susp = powered && (state != ST_SOFT_OFF);
    next_run = powered && (state == ST_RUN || state == ST_STANDBY);
    next_irq_pull = |(next_irq_status & ~next_irq_mask);
    next_aon_pull = !(i_system_supply_ok && powered);
    next_glb_pull = !(i_system_supply_ok && next_run);
    next_gpo_pull = !next_gpo_ctrl[GPO_BIT];
    // Pin is active high after external inversion, so hot releases it
    next_hot_pull = !hot_any;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_small_ldo_rail_b_en <= 1'b0;
      o_small_ldo_rail_c_en <= 1'b0;
      o_first_load_switch_en <= 1'b0;
      o_soft_off_rails_en <= 1'b0;
      o_suspend_rails_en <= 1'b0;
      o_run_rails_en <= 1'b0;
      o_interrupt_out_n_oe <= 1'b0;
      o_always_on_power_good_out_oe <= 1'b1;
      o_global_power_good_out_oe <= 1'b1;
      o_general_output_pin_oe <= 1'b1;
      o_thermal_warning_out_oe <= 1'b1;
    end else begin
      o_small_ldo_rail_b_en <= next_ldo_b;
      o_small_ldo_rail_c_en <= next_ldo_c;
      o_first_load_switch_en <= next_sw_a;
      o_soft_off_rails_en <= next_soft;
      o_suspend_rails_en <= next_susp;
      o_run_rails_en <= next_run;
      o_interrupt_out_n_oe <= next_irq_pull;
      o_always_on_power_good_out_oe <= next_aon_pull;
      o_global_power_good_out_oe <= next_glb_pull;
      o_general_output_pin_oe <= next_gpo_pull;
      o_thermal_warning_out_oe <= next_hot_pull;
    end
  end

  // Open-drain data lines only ever pull low
  assign o_interrupt_out_n = 1'b0;
  assign o_always_on_power_good_out = 1'b0;
  assign o_global_power_good_out = 1'b0;
  assign o_general_output_pin = 1'b0;
  assign o_thermal_warning_out = 1'b0;

endmodule

// >>> verif/power_state_pin_control_sva.sv
/*
 * Checker for the power state pin block, on its top-level ports.
 * Assumes it is bound into the block and shares its clock and reset.
 */
`timescale 1ns/1ps
module power_state_pin_control_sva
  import power_state_pkg::*;
#(
  parameter int N_SENSORS = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cold_boot_in,
  input wire logic i_combined_rail_enable_in,
  input wire logic i_otp_combined_mode,
  input wire logic i_hibernate_sleep_in_n,
  input wire logic i_thermal_trip_in_n,
  input wire logic [N_SENSORS-1:0] i_hot_threshold,
  input wire logic i_system_supply_ok,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic o_small_ldo_rail_b_en,
  input wire logic o_small_ldo_rail_c_en,
  input wire logic o_first_load_switch_en,
  input wire logic o_soft_off_rails_en,
  input wire logic o_suspend_rails_en,
  input wire logic o_run_rails_en,
  input wire logic o_interrupt_out_n,
  input wire logic o_always_on_power_good_out,
  input wire logic o_always_on_power_good_out_oe,
  input wire logic o_global_power_good_out,
  input wire logic o_global_power_good_out_oe,
  input wire logic o_general_output_pin,
  input wire logic o_general_output_pin_oe,
  input wire logic o_thermal_warning_out,
  input wire logic o_thermal_warning_out_oe
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_od_never_high: assert property (
    !(o_interrupt_out_n | o_always_on_power_good_out |
      o_global_power_good_out | o_general_output_pin | o_thermal_warning_out))
    else $error("open-drain output driven high");
  a_cold_low_off: assert property (
    !i_cold_boot_in [*6] |-> !(o_small_ldo_rail_b_en | o_small_ldo_rail_c_en |
      o_first_load_switch_en | o_soft_off_rails_en | o_suspend_rails_en |
      o_run_rails_en))
    else $error("rail enabled with cold boot low");
  a_gpo_set_release: assert property (
    i_reg_write && i_reg_addr == ADDR_GPO_CTRL && i_reg_wdata[GPO_BIT]
    |-> ##[1:2] !o_general_output_pin_oe)
    else $error("general output not released");
  a_gpo_clr_pull: assert property (
    i_reg_write && i_reg_addr == ADDR_GPO_CTRL && !i_reg_wdata[GPO_BIT]
    |-> ##[1:2] o_general_output_pin_oe)
    else $error("general output not pulled");
  a_hot_warns: assert property (
    (|i_hot_threshold) [*6] |-> !o_thermal_warning_out_oe)
    else $error("thermal warning missing");
  a_no_supply_pg: assert property (
    !i_system_supply_ok [*3]
    |-> o_always_on_power_good_out_oe && o_global_power_good_out_oe)
    else $error("power good released without supply");
  a_pin_switch_on: assert property (
    (i_combined_rail_enable_in && i_cold_boot_in && o_soft_off_rails_en) [*6]
    |-> o_first_load_switch_en)
    else $error("load switch off with enable pin high");
  a_pin_ldo_on: assert property (
    (i_combined_rail_enable_in && i_otp_combined_mode && i_cold_boot_in &&
     o_soft_off_rails_en) [*6]
    |-> o_small_ldo_rail_b_en && o_small_ldo_rail_c_en)
    else $error("small rails off in combined mode");
  a_cold_rise_up: assert property (
    $rose(i_cold_boot_in) && i_thermal_trip_in_n
    |-> ##[2:6] o_soft_off_rails_en)
    else $error("cold boot rise did not leave off");
  a_hib_rise_s3: assert property (
    $rose(i_hibernate_sleep_in_n) && i_cold_boot_in && i_thermal_trip_in_n &&
    o_soft_off_rails_en && !o_suspend_rails_en
    |-> ##[2:6] o_suspend_rails_en)
    else $error("hibernate rise did not reach suspend");
endmodule

// >>> verif/host_pins_model.sv
/*
 * Host model: drives the cold-boot, rail enable, sleep and trip pins.
 * Assumes the bench calls drive from one process only.
 */
`timescale 1ns/1ps
module host_pins_model (
  input wire logic i_clk_sys,
  output logic o_cold_boot,
  output logic o_rail_pin,
  output logic o_standby_n,
  output logic o_suspend_n,
  output logic o_hibernate_n,
  output logic o_trip_n
);
  // Sleep pins start asserted, as a host holds them at power-up
  initial begin
    o_cold_boot = 1'b0;
    o_rail_pin = 1'b0;
    o_standby_n = 1'b0;
    o_suspend_n = 1'b0;
    o_hibernate_n = 1'b0;
    o_trip_n = 1'b1;
  end

  task automatic drive(input int sel, input logic v);
    @(posedge i_clk_sys);
    case (sel)
      0: o_cold_boot <= v;
      1: o_rail_pin <= v;
      2: o_standby_n <= v;
      3: o_suspend_n <= v;
      4: o_hibernate_n <= v;
      default: o_trip_n <= v;
    endcase
  endtask
endmodule

// >>> verif/power_state_pin_control_tb.sv
/*
 * Bench for the power state pin block: register tasks, pin walks and
 * rail, interrupt and open-drain checks.
 * Assumes the checker and host model are compiled before it.
 */
`timescale 1ns/1ps
module power_state_pin_control_tb
  import power_state_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_rst_n, i_otp_combined_mode, i_system_supply_ok;
  logic i_cold_boot_in, i_combined_rail_enable_in, i_thermal_trip_in_n;
  logic i_standby_sleep_in_n, i_suspend_sleep_in_n, i_hibernate_sleep_in_n;
  logic [3:0] i_hot_threshold;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic i_reg_write, i_reg_read;
  logic o_small_ldo_rail_b_en, o_small_ldo_rail_c_en, o_first_load_switch_en;
  logic o_soft_off_rails_en, o_suspend_rails_en, o_run_rails_en;
  logic o_interrupt_out_n, o_interrupt_out_n_oe;
  logic o_always_on_power_good_out, o_always_on_power_good_out_oe;
  logic o_global_power_good_out, o_global_power_good_out_oe;
  logic o_general_output_pin, o_general_output_pin_oe;
  logic o_thermal_warning_out, o_thermal_warning_out_oe;
  logic [2:0] rails;
  int fails = 0;
  int n_tests = 0;
  int step_sel[12] = '{0, 3, 3, 4, 3, 2, 2, 2, 3, 4, 5, 0};
  logic step_val[12] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
    1'b0, 1'b0, 1'b0, 1'b0};
  logic [7:0] step_st[12] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h03,
    8'h04, 8'h03, 8'h02, 8'h01, 8'h00, 8'h00};

  assign rails = {o_small_ldo_rail_b_en, o_small_ldo_rail_c_en,
    o_first_load_switch_en};
  always #2 i_clk_sys = ~i_clk_sys;

  power_state_pin_control u_dut (.*);
  host_pins_model u_host (.i_clk_sys(i_clk_sys), .o_cold_boot(i_cold_boot_in),
    .o_rail_pin(i_combined_rail_enable_in), .o_standby_n(i_standby_sleep_in_n),
    .o_suspend_n(i_suspend_sleep_in_n), .o_hibernate_n(i_hibernate_sleep_in_n),
    .o_trip_n(i_thermal_trip_in_n));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_read <= 1'b0;
    #1;
    chk(o_reg_rdata, e);
  endtask

  // Pin path is two flops, an edge compare and an output flop
  task automatic pin_step(input int i);
    u_host.drive(step_sel[i], step_val[i]);
    repeat (6) @(posedge i_clk_sys);
    rd(ADDR_STATE, step_st[i]);
  endtask

  task automatic set_wait(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (6) @(posedge i_clk_sys);
  endtask

  task automatic do_reset(input logic mode);
    i_rst_n <= 1'b0;
    i_otp_combined_mode <= mode;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    i_rst_n = 1'b0;
    i_otp_combined_mode = 1'b1;
    i_system_supply_ok = 1'b1;
    i_hot_threshold = 4'h0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_reg_write = 1'b0;
    i_reg_read = 1'b0;
    do_reset(1'b1);
    rd(ADDR_STATE, 8'h00);
    rd(ADDR_GPO_CTRL, RST_GPO_CTRL);
    rd(ADDR_IRQ_MASK, RST_IRQ_MASK);
    rd(ADDR_RAIL_EN_LDO, RST_RAIL_EN_LDO);
    rd(ADDR_RAIL_EN_SW, RST_RAIL_EN_SW);
    wr(8'h55, 8'hAA);
    rd(8'h55, READ_NONE);
    for (int i = 0; i < 8; i++) begin
      pin_step(i);
    end
    chk(8'({o_soft_off_rails_en, o_suspend_rails_en, o_run_rails_en}),
      8'h07);
    rd(ADDR_PIN_STATUS, 8'hAF);
    chk(8'({o_always_on_power_good_out_oe, o_global_power_good_out_oe}),
      8'h00);
    rd(ADDR_IRQ_STATUS, 8'h01);
    chk(8'(o_interrupt_out_n_oe), 8'h01);
    set_wait(ADDR_IRQ_MASK, 8'h01);
    chk(8'(o_interrupt_out_n_oe), 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    set_wait(ADDR_IRQ_STATUS, 8'h0F);
    chk(8'(o_interrupt_out_n_oe), 8'h00);
    u_host.drive(1, 1'b1);
    repeat (6) @(posedge i_clk_sys);
    chk(8'(rails), 8'h07);
    u_host.drive(1, 1'b0);
    repeat (6) @(posedge i_clk_sys);
    chk(8'(rails), 8'h00);
    wr(ADDR_RAIL_EN_LDO, 8'h03);
    set_wait(ADDR_RAIL_EN_SW, 8'h01);
    chk(8'(rails), 8'h07);
    rd(ADDR_RAIL_EN_LDO, 8'h03);
    wr(ADDR_RAIL_EN_LDO, 8'h01);
    set_wait(ADDR_RAIL_EN_SW, 8'h00);
    chk(8'(rails), 8'h04);
    set_wait(ADDR_GPO_CTRL, 8'h01);
    chk(8'(o_general_output_pin_oe), 8'h00);
    set_wait(ADDR_GPO_CTRL, 8'h00);
    chk(8'(o_general_output_pin_oe), 8'h01);
    i_hot_threshold <= 4'h4;
    repeat (6) @(posedge i_clk_sys);
    chk(8'(o_thermal_warning_out_oe), 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h02);
    @(posedge i_clk_sys);
    i_hot_threshold <= 4'h0;
    i_system_supply_ok <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(8'({o_always_on_power_good_out_oe, o_global_power_good_out_oe}),
      8'h03);
    i_system_supply_ok <= 1'b1;
    for (int i = 8; i < 12; i++) begin
      pin_step(i);
    end
    chk(8'({rails, o_soft_off_rails_en, o_suspend_rails_en, o_run_rails_en}),
      8'h00);
    rd(ADDR_IRQ_STATUS, 8'h0F);
    u_host.drive(5, 1'b1);
    do_reset(1'b0);
    pin_step(0);
    u_host.drive(1, 1'b1);
    repeat (6) @(posedge i_clk_sys);
    chk(8'(rails), 8'h01);
    rd(ADDR_PIN_STATUS, 8'h33);
    set_wait(ADDR_RAIL_EN_LDO, 8'h03);
    chk(8'(rails), 8'h07);
    print_verdict();
  end

  // Whole run is well under 2000 cycles
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    fails++;
    print_verdict();
  end
endmodule

bind power_state_pin_control power_state_pin_control_sva
  #(.N_SENSORS(N_SENSORS)) u_sva (.*);
